// File: rtl/pdcc_pkg.sv
package pdcc_pkg;
   // ----------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [11:0] DEVICE_CAPABILITIES_OFS = 12'h0C4;
   localparam logic [11:0] DEVICE_CONTROL_OFS = 12'h0C8;
   // ----------------------------------------
   // Payload size encodings
   // ----------------------------------------
   localparam logic [2:0] PAYLOAD_128 = 3'h0;
   localparam logic [2:0] PAYLOAD_256 = 3'h1;
   localparam logic [2:0] PAYLOAD_512 = 3'h2;
   // ----------------------------------------
   // Capability field positions
   // ----------------------------------------
   localparam int CAP_MPS_LSB = 0;
   localparam int CAP_RBER_BIT = 15;
   localparam int CAP_SPL_VAL_LSB = 18;
   localparam int CAP_SPL_SCL_LSB = 26;
   // ----------------------------------------
   // Control field positions
   // ----------------------------------------
   localparam int CTL_ERR_LSB = 0;
   localparam int CTL_MPS_LSB = 5;
   localparam int CTL_AUX_BIT = 10;
   localparam int STS_ERR_LSB = 16;
   localparam int STS_AUX_DET_BIT = 20;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic RBER_RST = 1'h1;
   localparam logic [7:0] SPL_VAL_RST = 8'h00;
   localparam logic [1:0] SPL_SCL_RST = 2'h0;
   localparam logic [3:0] ERR_EN_RST = 4'h0;
   localparam logic [2:0] MPS_CTL_RST = 3'h0;
   localparam logic AUX_EN_RST = 1'h0;
endpackage

// File: rtl/pdcc_regs.sv
// How it works
// - Supported payload: 000b=128, 001b=256, 010b=512 bytes; others reserved.
// - Supported payload loads 001b with strap low, 010b with strap high.
// - Supported payload and role error bit defaults overridable by loader.
// - Phantom functions supported, capability bits 4:3, read 00b.
// - Extended tag supported, capability bit 5, reads zero.
// - L0s and L1 acceptable latency fields read-only 000b.
// - Capability bit 15 reads one after reset.
// - Upstream port captures slot power limit value into bits 25:18.
// - Upstream port captures slot power limit scale into bits 27:26.
// - Control bits 0-3 are error reporting enables, reset zero.
// - Relaxed ordering enable, control bit 4, reads zero.
// - Control bits 7:5 hold programmed payload size, reset 000b.
// - Payload writes above the supported value store the supported value.
// - Control bits 8 and 9 always read zero.
// - Control bit 10 is the aux power enable, reset zero.
// - No-snoop enable, control bit 11, reads zero.
// - Max read request size bits 14:12 hardwired 000b.
// - Error detected flags set regardless of reporting enables.
`timescale 1ns/100ps
`default_nettype none
module pdcc_regs #(
   parameter bit UPSTREAM = 1'b1
) (
   input wire logic mclk_i,
   input wire logic rstn_i,
   input wire logic payload_large_strap_i,
   input wire logic cfg_wr_i,
   input wire logic cfg_rd_i,
   input wire logic [11:0] cfg_addr_i,
   input wire logic [3:0] cfg_be_i,
   input wire logic [31:0] cfg_wdata_i,
   output logic [31:0] cfg_rdata_o,
   output logic cfg_ack_o,
   input wire logic ovr_mps_we_i,
   input wire logic [2:0] ovr_mps_i,
   input wire logic ovr_rber_we_i,
   input wire logic ovr_rber_i,
   input wire logic spl_msg_i,
   input wire logic [7:0] spl_value_i,
   input wire logic [1:0] spl_scale_i,
   input wire logic [3:0] err_detect_i,
   input wire logic aux_power_det_i,
   output logic [3:0] err_report_en_o,
   output logic [2:0] mps_o,
   output logic aux_pm_en_o
);
   import pdcc_pkg::*;

   // ----------------------------------------
   // Capability, control and status state
   // ----------------------------------------
   logic strap_done;
   logic [2:0] mps_sup;
   logic rber;
   logic [7:0] spl_val;
   logic [1:0] spl_scl;
   logic [3:0] err_en;
   logic [2:0] mps_ctl;
   logic aux_en;
   logic [3:0] err_sts;
   logic [31:0] device_capabilities;
   logic [31:0] device_control;
   logic wr_ctl;
   logic [2:0] wr_mps;

   // Strap caught on first clock after reset release, not under async reset
   // strap sets payload
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         strap_done <= 1'b0;
         mps_sup <= PAYLOAD_256;
      end else if (!strap_done) begin
         strap_done <= 1'b1;
         mps_sup <= payload_large_strap_i ? PAYLOAD_512 : PAYLOAD_256;
      end else if (ovr_mps_we_i) begin
         mps_sup <= ovr_mps_i;
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rber <= RBER_RST;
      end else if (ovr_rber_we_i) begin
         rber <= ovr_rber_i;
      end
   end

   // Downstream ports ignore the message; the field stays zero there
   // capture power value
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         spl_val <= SPL_VAL_RST;
         spl_scl <= SPL_SCL_RST;
      end else if (UPSTREAM && spl_msg_i) begin
         spl_val <= spl_value_i;
         spl_scl <= spl_scale_i;
      end
   end

   // ----------------------------------------
   // Control writes
   // ----------------------------------------
   assign wr_ctl = cfg_wr_i && (cfg_addr_i == DEVICE_CONTROL_OFS);

   assign wr_mps = (cfg_wdata_i[CTL_MPS_LSB +: 3] > mps_sup) ? mps_sup
                   : cfg_wdata_i[CTL_MPS_LSB +: 3];

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         err_en <= ERR_EN_RST;
      end else if (wr_ctl && cfg_be_i[0]) begin
         err_en <= cfg_wdata_i[CTL_ERR_LSB +: 4];
      end
   end

   // Bits 7:5 lie wholly in byte lane 0; lane 0 gates the field
   // payload control
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         mps_ctl <= MPS_CTL_RST;
      end else if (wr_ctl && cfg_be_i[0]) begin
         mps_ctl <= wr_mps;
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         aux_en <= AUX_EN_RST;
      end else if (wr_ctl && cfg_be_i[1]) begin
         aux_en <= cfg_wdata_i[CTL_AUX_BIT];
      end
   end

   // Set wins over write-one-to-clear in the same cycle
   // log errors always
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         err_sts <= 4'h0;
      end else begin
         err_sts <= (err_sts & ~((wr_ctl && cfg_be_i[2])
                    ? cfg_wdata_i[STS_ERR_LSB +: 4] : 4'h0)) | err_detect_i;
      end
   end

   // ----------------------------------------
   // Read images
   // ----------------------------------------
   // payload encoding
   always_comb begin
      device_capabilities = 32'h0;
      device_capabilities[CAP_MPS_LSB +: 3] = mps_sup;
      device_capabilities[CAP_RBER_BIT] = rber;
      device_capabilities[CAP_SPL_VAL_LSB +: 8] = spl_val;
      device_capabilities[CAP_SPL_SCL_LSB +: 2] = spl_scl;
   end

   always_comb begin
      device_control = 32'h0;
      device_control[CTL_ERR_LSB +: 4] = err_en;
      device_control[CTL_MPS_LSB +: 3] = mps_ctl;
      device_control[CTL_AUX_BIT] = aux_en;
      device_control[STS_ERR_LSB +: 4] = err_sts;
      device_control[STS_AUX_DET_BIT] = aux_power_det_i;
   end

   // ----------------------------------------
   // Read port, one cycle latency
   // ----------------------------------------
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cfg_rdata_o <= 32'h0;
      end else if (cfg_rd_i) begin
         if (cfg_addr_i == DEVICE_CAPABILITIES_OFS) begin
            cfg_rdata_o <= device_capabilities;
         end else if (cfg_addr_i == DEVICE_CONTROL_OFS) begin
            cfg_rdata_o <= device_control;
         end else begin
            cfg_rdata_o <= 32'h0;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cfg_ack_o <= 1'b0;
      end else begin
         cfg_ack_o <= cfg_rd_i | cfg_wr_i;
      end
   end

   assign err_report_en_o = err_en;
   assign mps_o = mps_ctl;
   assign aux_pm_en_o = aux_en;
endmodule // pdcc_regs
`default_nettype wire

// File: dv/pdcc_regs_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module pdcc_regs_monitor (
   input wire logic mclk_i,
   input wire logic rstn_i,
   input wire logic cfg_wr_i,
   input wire logic cfg_rd_i,
   input wire logic [11:0] cfg_addr_i,
   input wire logic [3:0] cfg_be_i,
   input wire logic [31:0] cfg_wdata_i,
   input wire logic [31:0] cfg_rdata_o,
   input wire logic cfg_ack_o,
   input wire logic [3:0] err_report_en_o,
   input wire logic [2:0] mps_o,
   input wire logic aux_pm_en_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);
   wire w8 = cfg_wr_i && cfg_addr_i == 12'h0C8;
   wire r4 = cfg_rd_i && cfg_addr_i == 12'h0C4;
   wire r8 = cfg_rd_i && cfg_addr_i == 12'h0C8;
   // ----------------
   // Port checks
   // ----------------
   ack_pulse_a: assert property ((cfg_rd_i || cfg_wr_i) |=> cfg_ack_o)
      else $error("missing ack");
   ack_cause_a: assert property (cfg_ack_o |-> $past(cfg_rd_i || cfg_wr_i))
      else $error("stray ack");
   cap_zero_a: assert property (r4 |=> {cfg_rdata_o[31:28], cfg_rdata_o[17:16],
      cfg_rdata_o[14:3]} == 18'h0) else $error("capability zero field set");
   ctl_zero_a: assert property (r8 |=> {cfg_rdata_o[15:11], cfg_rdata_o[9:8],
      cfg_rdata_o[4]} == 8'h00) else $error("control zero field set");
   err_en_a: assert property (w8 && cfg_be_i[0] |=> err_report_en_o == $past(cfg_wdata_i[3:0]))
      else $error("error enables not written");
   aux_en_a: assert property (w8 && cfg_be_i[1] |=> aux_pm_en_o == $past(cfg_wdata_i[10]))
      else $error("aux enable not written");
   mps_max_a: assert property (w8 && cfg_be_i[0] |=> mps_o <= $past(cfg_wdata_i[7:5]))
      else $error("payload above written value");
   en_hold_a: assert property (!w8 |=> $stable({err_report_en_o, mps_o, aux_pm_en_o}))
      else $error("control changed without write");
   ctl_mirror_a: assert property (r8 |=> {cfg_rdata_o[10], cfg_rdata_o[7:5],
      cfg_rdata_o[3:0]} == {aux_pm_en_o, mps_o, err_report_en_o}) else $error("readback mismatch");
   cover property (w8 && cfg_be_i[0] && cfg_wdata_i[7:5] == 3'h7);
   cover property (r4);
   cover property (cfg_rd_i && cfg_addr_i == 12'h0D0);
endmodule // pdcc_regs_monitor
`default_nettype wire

// File: dv/pdcc_host.sv
`timescale 1ns/100ps
`default_nettype none
module pdcc_host (
   input wire logic mclk_i,
   input wire logic cfg_ack_i,
   input wire logic [31:0] cfg_rdata_i,
   output logic cfg_wr_o,
   output logic cfg_rd_o,
   output logic [11:0] cfg_addr_o,
   output logic [3:0] cfg_be_o,
   output logic [31:0] cfg_wdata_o
);
   logic ok;
   initial begin
      {cfg_wr_o, cfg_rd_o, cfg_addr_o, cfg_be_o, cfg_wdata_o} = '0;
   end
   // Answer latency is fixed at one cycle, so no polling
   task automatic xfer(input logic w, input logic [11:0] a, input logic [3:0] be,
      input logic [31:0] d, output logic [31:0] q);
      @(negedge mclk_i);
      {cfg_wr_o, cfg_rd_o, cfg_addr_o, cfg_be_o, cfg_wdata_o} = {w, !w, a, be, d};
      @(negedge mclk_i);
      {cfg_wr_o, cfg_rd_o} = 2'h0;
      // Idle bus shows junk, not the last value
      {cfg_addr_o, cfg_wdata_o} = {~a, ~d};
      ok = cfg_ack_i;
      q = cfg_rdata_i;
   endtask
endmodule // pdcc_host
`default_nettype wire

// File: dv/pdcc_regs_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module pdcc_regs_tb_top;
   import pdcc_pkg::*;
   localparam logic [11:0] CAP = DEVICE_CAPABILITIES_OFS;
   localparam logic [11:0] CTL = DEVICE_CONTROL_OFS;
   logic mclk_i = 1'h0;
   logic rstn_i = 1'h0;
   logic payload_large_strap_i = 1'h1;
   logic ovr_mps_we_i = 1'h0;
   logic ovr_rber_we_i = 1'h0;
   logic ovr_rber_i = 1'h0;
   logic [31:0] ds_rdata;
   logic spl_msg_i = 1'h0;
   logic aux_power_det_i = 1'h0;
   logic [2:0] ovr_mps_i = 3'h0;
   logic [7:0] spl_value_i = 8'h00;
   logic [1:0] spl_scale_i = 2'h0;
   logic [3:0] err_detect_i = 4'h0;
   logic cfg_wr_i, cfg_rd_i, cfg_ack_o, aux_pm_en_o;
   logic [11:0] cfg_addr_i;
   logic [3:0] cfg_be_i, err_report_en_o;
   logic [31:0] cfg_wdata_i, cfg_rdata_o;
   logic [2:0] mps_o;
   int num_errors = 0;
   int checked = 0;
   always #5 mclk_i = ~mclk_i;
   pdcc_host host (.mclk_i, .cfg_ack_i(cfg_ack_o), .cfg_rdata_i(cfg_rdata_o), .cfg_wr_o(cfg_wr_i),
      .cfg_rd_o(cfg_rd_i), .cfg_addr_o(cfg_addr_i), .cfg_be_o(cfg_be_i), .cfg_wdata_o(cfg_wdata_i));
   pdcc_regs DUT (.mclk_i, .rstn_i, .payload_large_strap_i, .cfg_wr_i, .cfg_rd_i, .cfg_addr_i,
      .cfg_be_i, .cfg_wdata_i, .cfg_rdata_o, .cfg_ack_o, .ovr_mps_we_i, .ovr_mps_i, .ovr_rber_we_i,
      .ovr_rber_i, .spl_msg_i, .spl_value_i, .spl_scale_i, .err_detect_i, .aux_power_det_i,
      .err_report_en_o, .mps_o, .aux_pm_en_o);
   // Downstream copy shares the bus; tb checks only its read data, the bound monitor checks all its outputs
   pdcc_regs #(.UPSTREAM(1'b0)) DUT_DS (.mclk_i, .rstn_i, .payload_large_strap_i, .cfg_wr_i,
      .cfg_rd_i, .cfg_addr_i, .cfg_be_i, .cfg_wdata_i, .cfg_rdata_o(ds_rdata), .cfg_ack_o(),
      .ovr_mps_we_i, .ovr_mps_i, .ovr_rber_we_i, .ovr_rber_i, .spl_msg_i, .spl_value_i,
      .spl_scale_i, .err_detect_i, .aux_power_det_i, .err_report_en_o(), .mps_o(),
      .aux_pm_en_o());
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic close_out();
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic acc(input logic w, input logic [11:0] a, input logic [3:0] be,
      input logic [31:0] d, input logic [31:0] e);
      logic [31:0] q;
      host.xfer(w, a, be, d, q);
      chk("ack", 32'(host.ok), 32'h1);
      if (host.ok !== 1'h1) close_out();
      if (!w) chk("rdata", q, e);
   endtask
   task automatic do_reset(input logic s);
      @(negedge mclk_i);
      rstn_i = 1'h0;
      payload_large_strap_i = s;
      repeat (3) @(negedge mclk_i);
      rstn_i = 1'h1;
      @(negedge mclk_i);
   endtask
   // ----------------
   // Main sequence
   // ----------------
   initial begin
      do_reset(1'h1);
      acc(1'h0, CAP, 4'h0, 32'h0, 32'h0000_8002);
      acc(1'h0, CTL, 4'h0, 32'h0, 32'h0);
      aux_power_det_i = 1'h1;
      acc(1'h1, CTL, 4'hF, 32'hFFFF_FFFF, 32'h0);
      acc(1'h0, CTL, 4'h0, 32'h0, 32'h0010_044F);
      chk("pins", {24'h0, err_report_en_o, mps_o, aux_pm_en_o}, 32'hF5);
      acc(1'h1, CTL, 4'h1, 32'h20, 32'h0);
      acc(1'h0, CTL, 4'h0, 32'h0, 32'h0010_0420);
      acc(1'h1, CAP, 4'hF, 32'hFFFF_FFFF, 32'h0);
      acc(1'h0, CAP, 4'h0, 32'h0, 32'h0000_8002);
      acc(1'h0, 12'h0D0, 4'h0, 32'h0, 32'h0);
      {spl_msg_i, spl_value_i, spl_scale_i, err_detect_i} = {1'h1, 8'hA5, 2'h3, 4'h5};
      @(negedge mclk_i);
      {spl_msg_i, err_detect_i} = 5'h00;
      acc(1'h0, CAP, 4'h0, 32'h0, 32'h0E94_8002);
      chk("ds_cap", ds_rdata, 32'h0000_8002);
      acc(1'h0, CTL, 4'h0, 32'h0, 32'h0015_0420);
      acc(1'h1, CTL, 4'h4, 32'h0001_0000, 32'h0);
      acc(1'h0, CTL, 4'h0, 32'h0, 32'h0014_0420);
      {ovr_mps_we_i, ovr_rber_we_i} = 2'h3;
      @(negedge mclk_i);
      {ovr_mps_we_i, ovr_rber_we_i} = 2'h0;
      acc(1'h0, CAP, 4'h0, 32'h0, 32'h0E94_0000);
      acc(1'h1, CTL, 4'h1, 32'h40, 32'h0);
      chk("pins", {24'h0, err_report_en_o, mps_o, aux_pm_en_o}, 32'h01);
      do_reset(1'h0);
      acc(1'h0, CAP, 4'h0, 32'h0, 32'h0000_8001);
      acc(1'h1, CTL, 4'hF, 32'hE0, 32'h0);
      acc(1'h0, CTL, 4'h0, 32'h0, 32'h0010_0020);
      close_out();
   end
endmodule // pdcc_regs_tb_top
bind pdcc_regs pdcc_regs_monitor mon (.mclk_i, .rstn_i, .cfg_wr_i, .cfg_rd_i, .cfg_addr_i,
   .cfg_be_i, .cfg_wdata_i, .cfg_rdata_o, .cfg_ack_o, .err_report_en_o, .mps_o, .aux_pm_en_o);
`default_nettype wire
